// ===== hdl/pcs_pkg.sv
// Constants, types and register map of the primary clock select block.
// Assumes one 50 MHz system clock and reset config straps sampled in reset.
//
// Overview of operation
// - Host mode with bus clock driving enabled selects the reference clock as primary.
// - In that mode the reference clock feeds the halving divider and the output selectors.
// - The sync output carries the reference clock or its half, per the halving config.
// - Each bus clock output is driven only while its own output clock control bit is set.
// - The internal clock subsystem tracks the looped-back sync input.
// - Agent mode selects the external bus clock as primary.
// - Host mode with driving disabled selects the sync input as primary.
// - The primary clock is multiplied into the comms clock; system, memory and local bus clocks follow the sync input.
// - System clock equals sync frequency times one plus halving times the system multiplier.
// - Comms clock equals primary times comms multiplier over one plus comms divider.
// - Memory clock equals system clock times one plus its ratio, halved for the bus.
package pcs_pkg;

  localparam int unsigned PCS_NUM_BUS_CLK = 3;
  localparam int unsigned PCS_CNT_W = 10;
  localparam int unsigned PCS_FREQ_W = 20;

  // Measuring window: edges seen per window give frequency in 50 kHz units
  localparam int unsigned PCS_CLK_PERIOD_NS = 20;
  localparam int unsigned PCS_WINDOW_NS = 20000;
  localparam int unsigned PCS_WINDOW_CYC = PCS_WINDOW_NS / PCS_CLK_PERIOD_NS;

  localparam logic [7:0] PCS_OFS_OCC = 8'h00;
  localparam logic [7:0] PCS_OFS_STATUS = 8'h04;
  localparam logic [7:0] PCS_OFS_SYNC_CNT = 8'h08;
  localparam logic [7:0] PCS_OFS_CSB = 8'h0C;
  localparam logic [7:0] PCS_OFS_CE = 8'h10;
  localparam logic [7:0] PCS_OFS_MEM = 8'h14;
  localparam logic [7:0] PCS_OFS_MEM_BUS = 8'h18;
  localparam logic [7:0] PCS_OFS_LB = 8'h1C;

  localparam logic [PCS_NUM_BUS_CLK-1:0] PCS_OCC_RST = 3'h0;

  // Status register field positions
  localparam int unsigned PCS_ST_HOST = 0;
  localparam int unsigned PCS_ST_DRV = 1;
  localparam int unsigned PCS_ST_HALVE = 2;
  localparam int unsigned PCS_ST_LOCK = 3;
  localparam int unsigned PCS_ST_SRC = 4;

  typedef enum logic [2:0] {
    PCS_SRC_REF = 3'h1,
    PCS_SRC_BUS = 3'h2,
    PCS_SRC_SYNC = 3'h4
  } pcs_src_t;

  typedef struct packed {
    logic host_mode_select;
    logic bus_clock_drive_enable;
    logic ref_halving_config;
    logic [3:0] system_pll_multiplier;
    logic [4:0] comms_pll_multiplier;
    logic comms_pll_divider;
    logic memctl_one_clock_ratio;
    logic local_bus_clock_ratio;
  } pcs_cfg_t;

  typedef struct packed {
    logic [PCS_FREQ_W-1:0] csb;
    logic [PCS_FREQ_W-1:0] ce;
    logic [PCS_FREQ_W-1:0] mem;
    logic [PCS_FREQ_W-1:0] mem_bus;
    logic [PCS_FREQ_W-1:0] lb;
  } pcs_freq_t;

endpackage

// ===== hdl/pcs_edge_meter.sv
// Counts rising edges of a sampled clock level over a fixed window.
// Assumes the level is already synchronous to clk_i.
`timescale 1ns/10ps
module pcs_edge_meter (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic level_i,
  output logic [pcs_pkg::PCS_CNT_W-1:0] count_o
);

  localparam logic [pcs_pkg::PCS_CNT_W-1:0] LAST_CYC =
    pcs_pkg::PCS_CNT_W'(pcs_pkg::PCS_WINDOW_CYC - 1);

  logic level_q;
  logic [pcs_pkg::PCS_CNT_W-1:0] timer;
  logic [pcs_pkg::PCS_CNT_W-1:0] edges;
  logic rise;

  assign rise = level_i & ~level_q;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      level_q <= 1'b0;
    else
      level_q <= level_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      timer <= '0;
      edges <= '0;
      count_o <= '0;
    end
    else if (timer == LAST_CYC)
    begin
      // Edge on the closing cycle opens the next window
      timer <= '0;
      edges <= pcs_pkg::PCS_CNT_W'(rise);
      count_o <= edges;
    end
    else
    begin
      timer <= timer + 1'b1;
      edges <= edges + pcs_pkg::PCS_CNT_W'(rise);
    end
  end

endmodule // pcs_edge_meter

// ===== hdl/pcs_top.sv
// Primary clock select: source choice, sync and bus clock outputs,
// derived clock frequency figures, and an APB register slave.
// Assumes clock pins are sampled levels synchronous to clk_i and
// that the board loops the sync output back to the sync input.
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/10ps
module pcs_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire pcs_pkg::pcs_cfg_t reset_config_i,
  input wire logic reference_clock_input_i,
  input wire logic bus_clock_i,
  input wire logic sync_in_i,
  output logic sync_out_o,
  output logic [pcs_pkg::PCS_NUM_BUS_CLK-1:0] bus_clock_out_o,
  output logic [pcs_pkg::PCS_NUM_BUS_CLK-1:0] bus_clock_output_enable_o,
  output logic primary_clock_o,
  output pcs_pkg::pcs_freq_t freq_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  localparam int unsigned FW = pcs_pkg::PCS_FREQ_W;

  pcs_pkg::pcs_cfg_t cfg;
  pcs_pkg::pcs_src_t src;
  pcs_pkg::pcs_src_t next_src;
  logic [pcs_pkg::PCS_NUM_BUS_CLK-1:0] output_clock_control;
  logic ref_q;
  logic ref_half;
  logic next_sync_out;
  logic next_primary;
  logic sync_locked;
  logic [pcs_pkg::PCS_CNT_W-1:0] sync_count;
  logic [pcs_pkg::PCS_CNT_W-1:0] prim_count;
  logic [FW-1:0] next_csb;
  logic [FW-1:0] next_ce;
  logic apb_access;
  logic apb_hit;
  logic [31:0] next_rdata;

  // Straps are sampled on every reset cycle and frozen from release on
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      cfg <= reset_config_i;
  end

  always_comb
  begin
    if (!reset_config_i.host_mode_select)
      next_src = pcs_pkg::PCS_SRC_BUS;
    else if (reset_config_i.bus_clock_drive_enable)
      next_src = pcs_pkg::PCS_SRC_REF;
    else
      next_src = pcs_pkg::PCS_SRC_SYNC;
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      src <= next_src;
  end

  always_comb
  begin
    case (src)
      pcs_pkg::PCS_SRC_REF: next_primary = reference_clock_input_i;
      pcs_pkg::PCS_SRC_BUS: next_primary = bus_clock_i;
      pcs_pkg::PCS_SRC_SYNC: next_primary = sync_in_i;
      default: next_primary = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      primary_clock_o <= 1'b0;
    else
      primary_clock_o <= next_primary;
  end

  // Halving divider toggles on each reference rising edge
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      ref_q <= 1'b0;
      ref_half <= 1'b0;
    end
    else
    begin
      ref_q <= reference_clock_input_i;
      if (reference_clock_input_i && !ref_q)
        ref_half <= ~ref_half;
    end
  end

  // Output selectors only run in the driving host setup; otherwise the
  // bus clock pins are released, the sync output is driven low, and the board owns clock distribution
  assign next_sync_out = cfg.ref_halving_config ? ref_half : ref_q;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      sync_out_o <= 1'b0;
    else if (src == pcs_pkg::PCS_SRC_REF)
      sync_out_o <= next_sync_out;
    else
      sync_out_o <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      bus_clock_out_o <= '0;
    else if (src == pcs_pkg::PCS_SRC_REF)
      bus_clock_out_o <= {pcs_pkg::PCS_NUM_BUS_CLK{ref_half}}
        & output_clock_control;
    else
      bus_clock_out_o <= '0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      bus_clock_output_enable_o <= '0;
    else if (src == pcs_pkg::PCS_SRC_REF)
      bus_clock_output_enable_o <= output_clock_control;
    else
      bus_clock_output_enable_o <= '0;
  end

  pcs_edge_meter u_sync_meter (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .level_i(sync_in_i),
    .count_o(sync_count)
  );

  pcs_edge_meter u_prim_meter (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .level_i(primary_clock_o),
    .count_o(prim_count)
  );

  // Lock only means edges arrive; phase is not checked
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      sync_locked <= 1'b0;
    else
      sync_locked <= (sync_count != '0);
  end

  // System clock is locked to the sync input, comms clock to primary
  assign next_csb = FW'(sync_count)
    * FW'({1'b0, cfg.ref_halving_config} + 2'h1)
    * FW'(cfg.system_pll_multiplier);
  assign next_ce = (FW'(prim_count) * FW'(cfg.comms_pll_multiplier))
    >> cfg.comms_pll_divider;

  // Memory and local bus figures trail the system figure by one cycle, memory bus by two
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      freq_o <= '0;
    else
    begin
      freq_o.csb <= next_csb;
      freq_o.ce <= next_ce;
      freq_o.mem <= freq_o.csb << cfg.memctl_one_clock_ratio;
      freq_o.mem_bus <= freq_o.mem >> 1;
      freq_o.lb <= freq_o.csb << cfg.local_bus_clock_ratio;
    end
  end

  // APB slave: zero wait states, error on unmapped addresses
  assign apb_access = psel_i && penable_i;
  assign pready_o = 1'b1;

  always_comb
  begin
    apb_hit = 1'b1;
    next_rdata = 32'h0000_0000;
    case (paddr_i)
      pcs_pkg::PCS_OFS_OCC:
        next_rdata = 32'(output_clock_control);
      pcs_pkg::PCS_OFS_STATUS:
      begin
        next_rdata[pcs_pkg::PCS_ST_HOST] = cfg.host_mode_select;
        next_rdata[pcs_pkg::PCS_ST_DRV] = cfg.bus_clock_drive_enable;
        next_rdata[pcs_pkg::PCS_ST_HALVE] = cfg.ref_halving_config;
        next_rdata[pcs_pkg::PCS_ST_LOCK] = sync_locked;
        next_rdata[pcs_pkg::PCS_ST_SRC +: 3] = src;
      end
      pcs_pkg::PCS_OFS_SYNC_CNT: next_rdata = 32'(sync_count);
      pcs_pkg::PCS_OFS_CSB: next_rdata = 32'(freq_o.csb);
      pcs_pkg::PCS_OFS_CE: next_rdata = 32'(freq_o.ce);
      pcs_pkg::PCS_OFS_MEM: next_rdata = 32'(freq_o.mem);
      pcs_pkg::PCS_OFS_MEM_BUS: next_rdata = 32'(freq_o.mem_bus);
      pcs_pkg::PCS_OFS_LB: next_rdata = 32'(freq_o.lb);
      default: apb_hit = 1'b0;
    endcase
  end

  assign pslverr_o = apb_access && !apb_hit;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      output_clock_control <= pcs_pkg::PCS_OCC_RST;
    else if (apb_access && pwrite_i && paddr_i == pcs_pkg::PCS_OFS_OCC)
      output_clock_control <= pwdata_i[pcs_pkg::PCS_NUM_BUS_CLK-1:0];
  end

  // Read data is captured in the setup cycle so it is a flop at access
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      prdata_o <= 32'h0000_0000;
    else if (psel_i && !penable_i && !pwrite_i)
      prdata_o <= next_rdata;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  AST_SRC_REF: assert property (
    cfg.host_mode_select && cfg.bus_clock_drive_enable
      |-> src == pcs_pkg::PCS_SRC_REF)
    else $error("host drive setup did not pick reference clock");

  AST_SRC_BUS: assert property (
    !cfg.host_mode_select |-> ##1 primary_clock_o == $past(bus_clock_i))
    else $error("agent mode primary is not the bus clock");

  AST_SRC_SYNC: assert property (
    cfg.host_mode_select && !cfg.bus_clock_drive_enable
      |-> ##1 primary_clock_o == $past(sync_in_i))
    else $error("host without drive primary is not sync input");

  AST_HALF_TOGGLE: assert property (
    $rose(reference_clock_input_i) |=> ref_half != $past(ref_half))
    else $error("halving divider missed a reference edge");

  AST_SYNC_FULL: assert property (
    src == pcs_pkg::PCS_SRC_REF && !cfg.ref_halving_config
      |-> ##2 sync_out_o == $past(reference_clock_input_i, 2))
    else $error("sync output is not the undivided reference");

  AST_SYNC_HALF: assert property (
    src == pcs_pkg::PCS_SRC_REF && cfg.ref_halving_config
      |=> sync_out_o == $past(ref_half))
    else $error("sync output is not the halved reference");

  AST_BUS_GATE: assert property (
    ##1 (bus_clock_out_o & ~$past(output_clock_control)) == '0)
    else $error("bus clock output driven while its enable is clear");

  AST_LOCK: assert property (
    sync_count == '0 |=> !sync_locked)
    else $error("lock shown without sync edges");

  AST_CFG_HELD: assert property (
    nrst_i && $past(nrst_i) |-> $stable(cfg) && $stable(src))
    else $error("config changed outside reset");

  AST_MEM_RATIO: assert property (
    ##1 freq_o.mem == ($past(freq_o.csb) << cfg.memctl_one_clock_ratio))
    else $error("memory clock figure does not follow system figure");

  AST_CE_RATIO: assert property (
    ##1 freq_o.ce == ($past(FW'(prim_count) * FW'(cfg.comms_pll_multiplier))
      >> cfg.comms_pll_divider))
    else $error("comms clock figure is wrong");

  AST_CSB_RATIO: assert property (
    ##1 freq_o.csb == ($past(FW'(sync_count)
      * FW'(cfg.system_pll_multiplier)) << cfg.ref_halving_config))
    else $error("system clock figure is wrong");

  AST_MEM_BUS_HALF: assert property (
    ##1 freq_o.mem_bus == ($past(freq_o.mem) >> 1))
    else $error("memory bus figure is not half the memory figure");

  AST_LB_RATIO: assert property (
    ##1 freq_o.lb == ($past(freq_o.csb) << cfg.local_bus_clock_ratio))
    else $error("local bus figure does not follow system figure");

  COV_SRC_REF: cover property (src == pcs_pkg::PCS_SRC_REF
    ##1 $rose(bus_clock_out_o[0]));
  COV_SRC_BUS: cover property (src == pcs_pkg::PCS_SRC_BUS && sync_locked);
  COV_SRC_SYNC: cover property (src == pcs_pkg::PCS_SRC_SYNC
    && freq_o.csb != '0);
  COV_SYNC_HALF: cover property (src == pcs_pkg::PCS_SRC_REF
    && cfg.ref_halving_config ##1 $rose(sync_out_o));
  COV_APB_ERR: cover property (pslverr_o);

endmodule // pcs_top

// ===== tb/pcs_board_model.sv
// Board side model: reference, bus and external sync clock sources.
// Assumes clk_i is the bench clock; every level changes after its edge.
`timescale 1ns/10ps
module pcs_board_model (
  input wire logic clk_i,
  input wire logic host_i,
  input wire logic ext_sync_i,
  input wire logic sync_out_i,
  output logic reference_clock_o,
  output logic bus_clock_o,
  output logic sync_in_o
);
  logic [3:0] cnt = 4'h0;

  always_ff @(posedge clk_i)
  begin
    cnt <= cnt + 4'h1;
  end

  // Agent boards park the reference input low
  assign reference_clock_o = host_i & cnt[2];
  // Irregular on purpose so a wrong source choice cannot match by luck
  assign bus_clock_o = cnt[1] ^ cnt[3];
  // External distribution when not driving, else the loop-back wire
  assign sync_in_o = ext_sync_i ? cnt[3] : sync_out_i;
endmodule // pcs_board_model

// ===== tb/tb.sv
// Self-checking bench for the primary clock select block.
// Assumes the board model loops the sync output back when driving.
`timescale 1ns/10ps
module tb;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  pcs_pkg::pcs_cfg_t cfg = '0;
  logic brd_host = 1'b0;
  logic brd_ext = 1'b0;
  logic ref_w;
  logic bus_w;
  logic sin_w;
  logic sout;
  logic [2:0] bco;
  logic [2:0] bcoe;
  logic prim;
  pcs_pkg::pcs_freq_t freq;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int n_fail = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic er;

  initial
  begin
    forever #10 clk_i = ~clk_i;
  end

  pcs_board_model i_board (.clk_i(clk_i), .host_i(brd_host),
    .ext_sync_i(brd_ext), .sync_out_i(sout), .reference_clock_o(ref_w),
    .bus_clock_o(bus_w), .sync_in_o(sin_w));

  pcs_top i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .reset_config_i(cfg),
    .reference_clock_input_i(ref_w), .bus_clock_i(bus_w),
    .sync_in_i(sin_w), .sync_out_o(sout), .bus_clock_out_o(bco),
    .bus_clock_output_enable_o(bcoe), .primary_clock_o(prim),
    .freq_o(freq), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rng(input string nm, input int lo, input int hi,
    input logic [19:0] g);
    samples_checked++;
    if ($isunknown(g) || !(g >= lo && g <= hi))
    begin
      n_fail++;
      $display("[FAIL] %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask

  // One APB transfer; caller stands just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int k;
    k = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1 && k < 16)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k == 16)
    begin
      n_fail++;
      give_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_i);
  endtask

  function automatic pcs_pkg::pcs_cfg_t mk(input logic h, input logic d,
    input logic v);
    pcs_pkg::pcs_cfg_t c;
    c = '{h, d, v, 4'h4, 5'h09, 1'b1, 1'b1, 1'b0};
    return c;
  endfunction

  task automatic boot(input pcs_pkg::pcs_cfg_t c);
    nrst_i <= 1'b0;
    cfg <= c;
    brd_host <= c.host_mode_select;
    brd_ext <= c.host_mode_select & ~c.bus_clock_drive_enable;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
  endtask

  task automatic t_mode(input pcs_pkg::pcs_cfg_t c, input logic [2:0] src);
    logic [31:0] r;
    logic [31:0] st;
    logic e;
    logic pin;
    boot(c);
    st = {25'h0, src, 1'b0, c.ref_halving_config,
      c.bus_clock_drive_enable, c.host_mode_select};
    apb(1'b0, pcs_pkg::PCS_OFS_STATUS, 32'h0, r, e);
    chk("status", st, r & 32'h77);
    // Straps move after reset; the chosen source must not follow
    cfg <= pcs_pkg::pcs_cfg_t'(c ^ 15'h6000);
    apb(1'b0, pcs_pkg::PCS_OFS_STATUS, 32'h0, r, e);
    chk("status held", st, r & 32'h77);
    @(negedge clk_i);
    repeat (24)
    begin
      pin = src[0] ? ref_w : (src[1] ? bus_w : sin_w);
      @(negedge clk_i);
      chk("primary", {31'h0, pin}, {31'h0, prim});
      if (!src[0])
        chk("idle outputs", 32'h0, {25'h0, bcoe, bco, sout});
    end
    @(posedge clk_i);
  endtask

  task automatic t_outs(input logic hv);
    logic [31:0] r;
    logic e;
    logic [1:0] rh;
    logic pr;
    logic pb;
    int nr;
    int nh;
    boot(mk(1'b1, 1'b1, hv));
    apb(1'b0, pcs_pkg::PCS_OFS_OCC, 32'h0, r, e);
    chk("occ reset", 32'h0, r);
    apb(1'b1, pcs_pkg::PCS_OFS_OCC, 32'hFFFF_FFFD, r, e);
    apb(1'b0, pcs_pkg::PCS_OFS_OCC, 32'h0, r, e);
    chk("occ readback", 32'h5, r);
    apb(1'b0, 8'hFC, 32'h0, r, e);
    chk("unmapped", 32'h1, {31'h0, e});
    rh = 2'h0;
    nr = 0;
    nh = 0;
    @(negedge clk_i);
    rh = {1'b0, ref_w};
    @(negedge clk_i);
    pr = ref_w;
    pb = bco[0];
    repeat (48)
    begin
      rh = {rh[0], ref_w};
      @(negedge clk_i);
      nr += int'(ref_w & ~pr);
      nh += int'(bco[0] & ~pb);
      pr = ref_w;
      pb = bco[0];
      chk("enables", 32'h5, {29'h0, bcoe});
      chk("gated pair", {31'h0, bco[0]}, {30'h0, bco[1], bco[2]});
      if (hv)
        chk("sync half", {31'h0, bco[0]}, {31'h0, sout});
      else
        chk("sync full", {31'h0, rh[1]}, {31'h0, sout});
    end
    chk("halving", 32'h1, {31'h0, (nh * 2 >= nr - 2 && nh * 2 <= nr + 2)});
    @(posedge clk_i);
  endtask

  initial
  begin
    t_mode(mk(1'b1, 1'b1, 1'b0), 3'h1);
    t_mode(mk(1'b0, 1'b1, 1'b0), 3'h2);
    t_mode(mk(1'b1, 1'b0, 1'b0), 3'h4);
    t_outs(1'b1);
    t_outs(1'b0);
    // Reference period 8 cycles: 124..126 edges per window
    repeat (2200) @(posedge clk_i);
    rng("csb", 496, 504, freq.csb);
    rng("ce", 558, 567, freq.ce);
    rng("mem", 992, 1008, freq.mem);
    rng("mem bus", 496, 504, freq.mem_bus);
    rng("local bus", 496, 504, freq.lb);
    apb(1'b0, pcs_pkg::PCS_OFS_CSB, 32'h0, rd, er);
    rng("csb reg", 496, 504, rd[19:0]);
    apb(1'b0, pcs_pkg::PCS_OFS_SYNC_CNT, 32'h0, rd, er);
    rng("sync count", 124, 126, rd[19:0]);
    apb(1'b0, pcs_pkg::PCS_OFS_STATUS, 32'h0, rd, er);
    chk("lock", 32'h8, rd & 32'h8);
    give_verdict();
  end
endmodule // tb
